// *** rtl/sofc_regs.vh ***
// register offsets, field positions and reset values of the output format bank
`ifndef SOFC_REGS_VH
`define SOFC_REGS_VH

// register addresses on the serial control port
`define SOFC_ADDR_FORMAT 13'h0014
`define SOFC_ADDR_DRIVER 13'h0015
`define SOFC_ADDR_PHASE 13'h0016
`define SOFC_ADDR_PATT_LOW 13'h0019
`define SOFC_ADDR_PATT_HIGH 13'h001A
`define SOFC_ADDR_UPDATE 13'h00FF

// reset values
`define SOFC_RST_FORMAT 8'h00
`define SOFC_RST_DRIVER 8'h00
`define SOFC_RST_PHASE 8'h03
`define SOFC_RST_PATT 8'h00

// writable bit masks, unused bits stay zero
`define SOFC_MASK_FORMAT 8'h47
`define SOFC_MASK_DRIVER 8'h30
`define SOFC_MASK_PHASE 8'h0F

// field positions
`define SOFC_BIT_LOWSWING 6
`define SOFC_BIT_INVERT 2
`define SOFC_FMT_HI 1
`define SOFC_FMT_LO 0
`define SOFC_TERM_HI 5
`define SOFC_TERM_LO 4
`define SOFC_PHASE_HI 3
`define SOFC_PHASE_LO 0
`define SOFC_BIT_TRANSFER 0

// field codes
`define SOFC_FMT_TWOS 2'h1
`define SOFC_PHASE_MAX 4'hA

// serial frame layout: 16 instruction bits then one data byte
`define SOFC_INSTR_LAST 5'h0F
`define SOFC_DATA_LAST 5'h17
`define SOFC_FRAME_DONE 5'h18

`endif

// *** rtl/sofc_format_regs.v ***
// serial output format register bank with its serial control port slave
`timescale 1ns/1ps
`include "sofc_regs.vh"

module sofc_format_regs #(
    parameter CHANNELS = 4,
    parameter SAMPLE_W = 8
) (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // serial control port pins
    input wire spiClk,
    input wire spiCsN,
    input wire spiDataIn,
    output wire spiDataOut,
    output wire spiDataOe,
    // converted samples and test selection
    input wire [CHANNELS*SAMPLE_W-1:0] sampleIn,
    input wire userPatternMode,
    // formatted output words
    output wire [CHANNELS*SAMPLE_W-1:0] dataOut,
    // working configuration toward the drivers
    output wire lowPowerSwing,
    output wire [1:0] termSelect,
    output wire term200Ohm,
    output wire term100Ohm,
    output wire [3:0] phaseSelect
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    reg [2:0] sclkSync_reg; // [0] feeds [1] only
    reg [1:0] csSync_reg; // chip select, active low
    reg [1:0] sdiSync_reg; // serial data in

    // two flops per pin, a third on clock for edge finding
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sclkSync_reg <= 3'h0;
            csSync_reg <= 2'h3;
            sdiSync_reg <= 2'h0;
        end else begin
            sclkSync_reg <= {sclkSync_reg[1:0], spiClk};
            csSync_reg <= {csSync_reg[0], spiCsN};
            sdiSync_reg <= {sdiSync_reg[0], spiDataIn};
        end
    end

    wire sclkRise = sclkSync_reg[1] & ~sclkSync_reg[2]; // rising edge
    wire sclkFall = ~sclkSync_reg[1] & sclkSync_reg[2]; // falling edge
    wire csActive = ~csSync_reg[1]; // frame in progress
    wire sdiBit = sdiSync_reg[1]; // sampled data bit

    // ************************************************************
    // master and working copies
    // ************************************************************
    reg [7:0] mFormat_reg; // master copies take writes
    reg [7:0] mDriver_reg;
    reg [7:0] mPhase_reg;
    reg [7:0] mPattLow_reg;
    reg [7:0] mPattHigh_reg;
    reg [7:0] wFormat_reg; // working copies drive the outputs
    reg [7:0] wDriver_reg;
    reg [7:0] wPhase_reg;
    reg [15:0] wPattern_reg;

    // ************************************************************
    // serial frame decoder
    // ************************************************************
    reg [4:0] bitCnt_reg; // bits seen in this frame
    reg [15:0] instr_reg; // instruction shift register
    reg isRead_reg; // frame is a read
    reg [12:0] addr_reg; // register address of the frame
    reg [7:0] wrShift_reg; // incoming data byte
    reg [7:0] rdShift_reg; // outgoing data byte
    reg sdo_reg; // bit on the data pin
    reg sdoEn_reg; // data pin driven
    reg wrStrobe_reg; // one-cycle write request
    reg [7:0] wrData_reg; // byte to write

    // instruction word once the last instruction bit arrives
    wire [15:0] instrNext = {instr_reg[14:0], sdiBit};

    reg [7:0] readMux; // master register selected by address
    // read back the master copies, unused bits are zero
    always @* begin
        case (instrNext[12:0])
            `SOFC_ADDR_FORMAT: readMux = mFormat_reg;
            `SOFC_ADDR_DRIVER: readMux = mDriver_reg;
            `SOFC_ADDR_PHASE: readMux = mPhase_reg;
            `SOFC_ADDR_PATT_LOW: readMux = mPattLow_reg;
            `SOFC_ADDR_PATT_HIGH: readMux = mPattHigh_reg;
            default: readMux = 8'h00; // update and unmapped read zero
        endcase
    end

    // shift instruction and data, serve reads on falling edges
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bitCnt_reg <= 5'h00;
            instr_reg <= 16'h0000;
            isRead_reg <= 1'b0;
            addr_reg <= 13'h0000;
            wrShift_reg <= 8'h00;
            rdShift_reg <= 8'h00;
            sdo_reg <= 1'b0;
            sdoEn_reg <= 1'b0;
            wrStrobe_reg <= 1'b0;
            wrData_reg <= 8'h00;
        end else begin
            wrStrobe_reg <= 1'b0;
            if (!csActive) begin
                // idle: restart frame, release the pin
                bitCnt_reg <= 5'h00;
                sdoEn_reg <= 1'b0;
            end else if (sclkRise) begin
                if (bitCnt_reg != `SOFC_FRAME_DONE) begin
                    bitCnt_reg <= bitCnt_reg + 5'h01;
                end
                if (bitCnt_reg <= `SOFC_INSTR_LAST) begin
                    instr_reg <= instrNext;
                end
                if (bitCnt_reg == `SOFC_INSTR_LAST) begin
                    // first bit is read/write, low 13 bits address
                    isRead_reg <= instrNext[15];
                    addr_reg <= instrNext[12:0];
                    rdShift_reg <= readMux;
                end
                if (bitCnt_reg > `SOFC_INSTR_LAST &&
                    bitCnt_reg <= `SOFC_DATA_LAST && !isRead_reg) begin
                    wrShift_reg <= {wrShift_reg[6:0], sdiBit};
                end
                if (bitCnt_reg == `SOFC_DATA_LAST && !isRead_reg) begin
                    wrData_reg <= {wrShift_reg[6:0], sdiBit};
                    wrStrobe_reg <= 1'b1;
                end
            end else if (sclkFall && isRead_reg &&
                         bitCnt_reg > `SOFC_INSTR_LAST &&
                         bitCnt_reg <= `SOFC_DATA_LAST) begin
                // msb first, one bit per falling edge
                sdo_reg <= rdShift_reg[7];
                rdShift_reg <= {rdShift_reg[6:0], 1'b0};
                sdoEn_reg <= 1'b1;
            end
        end
    end

    assign spiDataOut = sdo_reg;
    assign spiDataOe = sdoEn_reg;

    // ************************************************************
    // register writes and transfer
    // ************************************************************
    // transfer request from the update register, self clearing
    wire transfer = wrStrobe_reg && addr_reg == `SOFC_ADDR_UPDATE &&
                    wrData_reg[`SOFC_BIT_TRANSFER];

    // writes land in the master copies only
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mFormat_reg <= `SOFC_RST_FORMAT;
            mDriver_reg <= `SOFC_RST_DRIVER;
            mPhase_reg <= `SOFC_RST_PHASE;
            mPattLow_reg <= `SOFC_RST_PATT;
            mPattHigh_reg <= `SOFC_RST_PATT;
        end else if (wrStrobe_reg) begin
            case (addr_reg)
                `SOFC_ADDR_FORMAT:
                    mFormat_reg <= wrData_reg & `SOFC_MASK_FORMAT;
                `SOFC_ADDR_DRIVER:
                    mDriver_reg <= wrData_reg & `SOFC_MASK_DRIVER;
                `SOFC_ADDR_PHASE: begin
                    // codes beyond the last valid step are ignored
                    if ((wrData_reg & `SOFC_MASK_PHASE) <=
                        {4'h0, `SOFC_PHASE_MAX}) begin
                        // unused upper bits never stored
                        mPhase_reg <= wrData_reg & `SOFC_MASK_PHASE;
                    end
                end
                `SOFC_ADDR_PATT_LOW: mPattLow_reg <= wrData_reg;
                `SOFC_ADDR_PATT_HIGH: mPattHigh_reg <= wrData_reg;
                default: ; // unmapped writes are dropped
            endcase
        end
    end

    // working copies follow the masters only on transfer
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wFormat_reg <= `SOFC_RST_FORMAT;
            wDriver_reg <= `SOFC_RST_DRIVER;
            wPhase_reg <= `SOFC_RST_PHASE;
            wPattern_reg <= {`SOFC_RST_PATT, `SOFC_RST_PATT};
        end else if (transfer) begin
            wFormat_reg <= mFormat_reg;
            wDriver_reg <= mDriver_reg;
            wPhase_reg <= mPhase_reg;
            wPattern_reg <= {mPattHigh_reg, mPattLow_reg};
        end
    end

    // ************************************************************
    // configuration outputs
    // ************************************************************
    assign lowPowerSwing = wFormat_reg[`SOFC_BIT_LOWSWING];
    assign termSelect = wDriver_reg[`SOFC_TERM_HI:`SOFC_TERM_LO];
    assign term200Ohm = termSelect == 2'h1;
    assign term100Ohm = termSelect[1];
    // phase only steers the clock driver, never the data path
    assign phaseSelect =
        wPhase_reg[`SOFC_PHASE_HI:`SOFC_PHASE_LO];

    // ************************************************************
    // per channel output data path
    // ************************************************************
    wire invertAll = wFormat_reg[`SOFC_BIT_INVERT];
    wire twosComp = wFormat_reg[`SOFC_FMT_HI:`SOFC_FMT_LO] == `SOFC_FMT_TWOS;
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : gChan
            reg [SAMPLE_W-1:0] word_reg; // registered output word
            // test pattern uses its top bits, msb justified
            wire [SAMPLE_W-1:0] rawWord = userPatternMode ?
                wPattern_reg[15 -: SAMPLE_W] :
                sampleIn[ch*SAMPLE_W +: SAMPLE_W];
            // twos complement flips the sign bit of offset binary
            wire [SAMPLE_W-1:0] fmtWord = twosComp ?
                {~rawWord[SAMPLE_W-1], rawWord[SAMPLE_W-2:0]} :
                rawWord;
            // latch on every clock regardless of phase setting
            always @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    word_reg <= {SAMPLE_W{1'b0}};
                end else begin
                    word_reg <= invertAll ? ~fmtWord : fmtWord;
                end
            end
            assign dataOut[ch*SAMPLE_W +: SAMPLE_W] = word_reg;
        end
    endgenerate

endmodule // sofc_format_regs

// *** testbench/sofc_format_monitor.sv ***
// concurrent checks on the ports of the output format bank
`timescale 1ns/1ps
module sofc_format_monitor #(
    parameter CHANNELS = 4,
    parameter SAMPLE_W = 8
) (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // serial port
    input wire spiCsN,
    input wire spiDataOe,
    // samples and formatted words
    input wire [CHANNELS*SAMPLE_W-1:0] sampleIn,
    input wire userPatternMode,
    input wire [CHANNELS*SAMPLE_W-1:0] dataOut,
    // working configuration
    input wire lowPowerSwing,
    input wire [1:0] termSelect,
    input wire term200Ohm,
    input wire term100Ohm,
    input wire [3:0] phaseSelect
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    reset_vals_a: assert property ($rose(rstn) |->
        phaseSelect == 4'h3 && termSelect == 2'h0 && !lowPowerSwing)
        else $error("config outputs not at reset values");
    term_mid_a: assert property (term200Ohm == (termSelect == 2'h1))
        else $error("mid termination flag wrong");
    term_low_a: assert property (term100Ohm == termSelect[1])
        else $error("low termination flag wrong");
    phase_range_a: assert property (phaseSelect <= 4'hA)
        else $error("phase code out of range");
    cfg_hold_a: assert property (
        $changed({lowPowerSwing, termSelect, phaseSelect}) |-> !spiDataOe)
        else $error("config changed during a read frame");
    oe_cause_a: assert property ($rose(spiDataOe) |-> !spiCsN)
        else $error("read data driven without select");
    oe_drop_a: assert property ($rose(spiCsN) |-> ##[1:5] !spiDataOe)
        else $error("read driver not released");
    data_hold_a: assert property (spiCsN && $past(spiCsN, 4)
        && $past(rstn, 3) && $stable(sampleIn) && $stable(userPatternMode)
        |=> $stable(dataOut)) else $error("output word changed on its own");
    read_cov: cover property ($rose(spiDataOe));
    phase_cov: cover property ($changed(phaseSelect));
    patt_cov: cover property ($rose(userPatternMode));
endmodule // sofc_format_monitor

// *** testbench/sofc_spi_host.sv ***
// serial control port host model driving the bank's register port
`timescale 1ns/1ps
module sofc_spi_host (
    // serial control port pins
    output reg spiClk,
    output reg spiCsN,
    output reg spiDataIn,
    input wire spiDataOut,
    input wire spiDataOe
);
    integer i;
    initial begin
        spiClk = 1'b0;
        spiCsN = 1'b1;
        spiDataIn = 1'b0;
    end
    // one frame: 16 instruction bits then one byte, msb first, 125 ns clock
    task xfer(input [15:0] instr, input [7:0] wd, output [7:0] rd);
        reg [23:0] sh;
        begin
            sh = {instr, wd};
            spiCsN <= 1'b0;
            for (i = 23; i >= 0; i = i - 1) begin
                // falling edge carries the next bit in both directions
                spiClk <= 1'b0;
                spiDataIn <= sh[i];
                #62.5 spiClk <= 1'b1;
                if (i < 8) rd[i] = spiDataOe ? spiDataOut : ~spiDataOut;
                #62.5;
            end
            spiClk <= 1'b0;
            #62.5 spiCsN <= 1'b1;
            // released line shows no stale level
            spiDataIn <= ~spiDataIn;
            #125;
        end
    endtask
endmodule // sofc_spi_host

// *** testbench/test_serial_output_format_config.sv ***
// self-checking bench for the output format register bank
`timescale 1ns/1ps
`include "sofc_regs.vh"
module test_serial_output_format_config;
    reg clk_sys = 1'b0;
    reg rstn = 1'b0;
    reg [31:0] sampleIn = 32'h0;
    reg userPatternMode = 1'b0;
    wire spiClk, spiCsN, spiDataIn, spiDataOut, spiDataOe;
    wire [31:0] dataOut;
    wire lowPowerSwing, term200Ohm, term100Ohm;
    wire [1:0] termSelect;
    wire [3:0] phaseSelect;
    integer n_mismatch = 0;
    integer n_checks = 0;
    integer k, c;
    reg [7:0] rd, b, m;
    reg [31:0] e;
    always #2.5 clk_sys = ~clk_sys;
    sofc_format_regs #(.CHANNELS(4), .SAMPLE_W(8)) i_sofc_format_regs (
        .clk_sys(clk_sys), .rstn(rstn), .spiClk(spiClk), .spiCsN(spiCsN),
        .spiDataIn(spiDataIn), .spiDataOut(spiDataOut),
        .spiDataOe(spiDataOe), .sampleIn(sampleIn),
        .userPatternMode(userPatternMode), .dataOut(dataOut),
        .lowPowerSwing(lowPowerSwing), .termSelect(termSelect),
        .term200Ohm(term200Ohm), .term100Ohm(term100Ohm),
        .phaseSelect(phaseSelect));
    sofc_spi_host i_sofc_spi_host (.spiClk(spiClk), .spiCsN(spiCsN),
        .spiDataIn(spiDataIn), .spiDataOut(spiDataOut),
        .spiDataOe(spiDataOe));
    task check(input string what, input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED %s expected %h seen %h",
                    what, exp, seen);
            end
        end
    endtask
    task wr(input [12:0] a, input [7:0] d);
        i_sofc_spi_host.xfer({3'b000, a}, d, rd);
    endtask
    task rdchk(input [12:0] a, input [7:0] exp);
        begin
            i_sofc_spi_host.xfer({3'b100, a}, 8'h00, rd);
            check("readback", rd, exp);
        end
    endtask
    // transfer master copies into the working registers
    task apply;
        begin
            wr(`SOFC_ADDR_UPDATE, 8'h01);
            repeat (4) @(posedge clk_sys);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_mismatch);
            if (n_mismatch == 0 && n_checks > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // reset values on outputs and readback
    task t_reset;
        begin
            check("phase", phaseSelect, 32'h3);
            check("term", termSelect, 32'h0);
            check("swing", lowPowerSwing, 32'h0);
            rdchk(`SOFC_ADDR_PATT_LOW, 8'h00);
            rdchk(`SOFC_ADDR_PATT_HIGH, 8'h00);
            rdchk(`SOFC_ADDR_PHASE, 8'h03);
            rdchk(`SOFC_ADDR_FORMAT, 8'h00);
        end
    endtask
    // unused bits, staged writes, unmapped reads
    task t_masks;
        begin
            wr(`SOFC_ADDR_FORMAT, 8'hFF);
            wr(`SOFC_ADDR_DRIVER, 8'hFF);
            rdchk(`SOFC_ADDR_FORMAT, 8'h47);
            rdchk(`SOFC_ADDR_DRIVER, 8'h30);
            rdchk(13'h0020, 8'h00);
            check("staged", lowPowerSwing, 32'h0);
            apply;
            check("swing", lowPowerSwing, 32'h1);
            rdchk(`SOFC_ADDR_UPDATE, 8'h00);
        end
    endtask
    // every termination code
    task t_term;
        for (k = 0; k < 4; k = k + 1) begin
            wr(`SOFC_ADDR_DRIVER, {2'h0, k[1:0], 4'hF});
            apply;
            check("term", termSelect, k);
            check("t200", term200Ohm, k == 1);
            check("t100", term100Ohm, k >= 2);
        end
    endtask
    // top phase code taken, one above refused
    task t_phase;
        begin
            wr(`SOFC_ADDR_PHASE, 8'h0A);
            apply;
            check("phase", phaseSelect, 32'hA);
            // inverted words of zero samples must not move with phase
            check("latch", dataOut, 32'hFFFFFFFF);
            wr(`SOFC_ADDR_PHASE, 8'h0B);
            rdchk(`SOFC_ADDR_PHASE, 8'h0A);
            wr(`SOFC_ADDR_PHASE, 8'hF3);
            rdchk(`SOFC_ADDR_PHASE, 8'h03);
            wr(`SOFC_ADDR_PHASE, 8'h00);
            apply;
            check("phase", phaseSelect, 32'h0);
        end
    endtask
    // pattern and samples through offset binary and twos complement, each with and without invert
    task t_data;
        begin
            wr(`SOFC_ADDR_PATT_LOW, 8'h34);
            wr(`SOFC_ADDR_PATT_HIGH, 8'hC5);
            rdchk(`SOFC_ADDR_PATT_LOW, 8'h34);
            for (k = 0; k < 8; k = k + 1) begin
                wr(`SOFC_ADDR_FORMAT, {5'h0, k[1], 1'b0, k[0]});
                apply;
                m = (k[0] ? 8'h80 : 8'h00) ^ (k[1] ? 8'hFF : 8'h00);
                @(posedge clk_sys);
                userPatternMode <= k[2];
                sampleIn <= 32'h7F0180FE;
                repeat (2) @(posedge clk_sys);
                for (c = 0; c < 4; c = c + 1) begin
                    b = k[2] ? 8'hC5 : sampleIn[c*8 +: 8];
                    e[c*8 +: 8] = b ^ m;
                end
                check("word", dataOut, e);
            end
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        t_reset;
        t_masks;
        t_term;
        t_phase;
        t_data;
        tally_and_finish;
    end
    // cut a hang short
    initial begin
        repeat (80000) @(posedge clk_sys);
        n_mismatch = n_mismatch + 1;
        tally_and_finish;
    end
endmodule // test_serial_output_format_config
bind sofc_format_regs sofc_format_monitor #(.CHANNELS(CHANNELS),
    .SAMPLE_W(SAMPLE_W)) i_sofc_format_monitor (.clk_sys, .rstn, .spiCsN,
    .spiDataOe, .sampleIn, .userPatternMode, .dataOut, .lowPowerSwing,
    .termSelect, .term200Ohm, .term100Ohm, .phaseSelect);
